/* logic/diag_pkg.sv */
// constants and types for the front-panel diagnostic display
// assumes a 50 MHz module clock
package diag_pkg;
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned LONG_PRESS_MS  = 1000;
  localparam int unsigned LONG_CYCLES    = CLK_HZ / 1000 * LONG_PRESS_MS;
  localparam int unsigned DEBOUNCE_MS    = 10;
  localparam int unsigned DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned FLASH_MS       = 250;
  localparam int unsigned FLASH_CYCLES   = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned NUM_LEDS       = 32;
  localparam int unsigned ADDR_W         = 5;
  localparam int unsigned CNT_W          = 26;
  localparam logic [4:0]  ADDR_FIRST     = 5'h01;
  localparam logic [4:0]  ADDR_LAST      = 5'h1F;
  localparam int unsigned IN_LO          = 0;
  localparam int unsigned OUT_LO         = 4;

  typedef enum logic [1:0] {
    BUS_VIEW,
    ADDR_VIEW,
    IO_VIEW
  } view_type;
endpackage

/* logic/press_if.sv */
// press classification results from one button to the display controller
// assumes one clock domain
`timescale 1ns/1ps
interface press_if;
  logic short_press;
  logic long_press;
  modport button (output short_press, output long_press);
  modport ctrl   (input short_press, input long_press);
endinterface

/* logic/button_press.sv */
// debounces one push button and classifies presses as short or long
// assumes the button level is synchronous to ref_clk, high while pressed
`timescale 1ns/1ps
module button_press
  import diag_pkg::*;
#(
  parameter int unsigned LONG_CNT = LONG_CYCLES,
  parameter int unsigned DEB_CNT  = DEBOUNCE_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // raw button level
  input  wire logic pressed,
  // classification
  press_if.button   res
);
  typedef struct packed {
    logic             stable;
    logic [CNT_W-1:0] deb;
    logic [CNT_W-1:0] held;
    logic             long_done;
    logic             short_p;
    logic             long_p;
  } state_type;

  state_type st;
  state_type next_st;

  always_comb begin
    next_st = st;
    next_st.short_p = 1'b0;
    next_st.long_p  = 1'b0;
    // debounce: level must stand for DEB_CNT cycles [R13]
    if (pressed == st.stable) begin
      next_st.deb = '0;
    end else if (st.deb >= CNT_W'(DEB_CNT - 1)) begin
      next_st.deb    = '0;
      next_st.stable = pressed;
    end else begin
      next_st.deb = st.deb + 1'b1;
    end
    if (st.stable) begin
      if (!st.long_done) begin
        if (st.held >= CNT_W'(LONG_CNT - 1)) begin
          next_st.long_done = 1'b1;
          next_st.long_p    = 1'b1; // acts once while held [R13]
        end else begin
          next_st.held = st.held + 1'b1;
        end
      end
      if (!next_st.stable) begin
        // a long pulse firing on the release edge wins, so the press acts only once
        next_st.short_p   = !st.long_done && !next_st.long_p; // released in time [R13]
        next_st.held      = '0;
        next_st.long_done = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign res.short_press = st.short_p;
  assign res.long_press  = st.long_p;

  chk_press_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
    !(st.short_p && st.long_p)) else $error("short and long press together");
  chk_long_once: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
    st.long_p |=> !st.long_p [*8]) else $error("long press repeated");
endmodule

/* logic/diag_display.sv */
// front-panel diagnostic display controller: 32 LED panel plus Bus and I/O LEDs
// assumes bus image and slave bits are synchronous to ref_clk; buttons high when pressed
// Function
// [R1] In Bus mode LEDs 1 to 31 each stand for the slave at that address.
// [R2] In Bus mode an LED is steady when expected and detected, flashes on mismatch, else dark.
// [R3] The address view lights only the LED numbered as the selected slave.
// [R4] The I/O view shows four input bits on LEDs 0-3 and four output bits on LEDs 4-7.
// [R5] In the I/O view a bit of 1 lights its LED, a 0 or absent bit leaves it dark.
// [R6] Mode LEDs: Bus view Bus on I/O off, address view both off, I/O view Bus off I/O on.
// [R7] After reset the display starts in Bus view.
// [R8] A long press of the direction button in Bus view enters the address view.
// [R9] In the address view a short step press moves one address, a short direction press reverses.
// [R10] In the address view a long step press enters the I/O view.
// [R11] In the I/O view a short step press moves to the next or previous slave by direction.
// [R12] In the I/O view a long step press returns to the address view.
// [R13] Both buttons are debounced and presses are classified short or long, long acting once.
// [R14] A long direction press in either slave view returns to Bus view.
`timescale 1ns/1ps
module diag_display
  import diag_pkg::*;
#(
  parameter int unsigned LONG_CNT  = LONG_CYCLES,
  parameter int unsigned DEB_CNT   = DEBOUNCE_CYCLES,
  parameter int unsigned FLASH_CNT = FLASH_CYCLES
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // push buttons, high while pressed
  input  wire logic                dir_button,
  input  wire logic                step_button,
  // bus image, bit n for slave address n
  input  wire logic [NUM_LEDS-1:0] slave_expected,
  input  wire logic [NUM_LEDS-1:0] slave_detected,
  // slave i/o, 4 bits per address, plus presence of each bit
  input  wire logic [127:0]        slave_inputs,
  input  wire logic [127:0]        slave_outputs,
  input  wire logic [127:0]        slave_in_valid,
  input  wire logic [127:0]        slave_out_valid,
  // panel
  output logic      [NUM_LEDS-1:0] panel_led,
  output logic                     bus_led,
  output logic                     io_led,
  output logic                     slave_view_mode
);
  press_if dir_p ();
  press_if step_p ();

  button_press #(.LONG_CNT(LONG_CNT), .DEB_CNT(DEB_CNT)) u_dir (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pressed (dir_button),
    .res     (dir_p)
  );

  button_press #(.LONG_CNT(LONG_CNT), .DEB_CNT(DEB_CNT)) u_step (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pressed (step_button),
    .res     (step_p)
  );

  typedef struct packed {
    view_type            view;
    logic [ADDR_W-1:0]   addr;
    logic                down;
    logic [CNT_W-1:0]    flash_cnt;
    logic                blink;
    logic [NUM_LEDS-1:0] leds;
    logic                bus_on;
    logic                io_on;
  } state_type;

  state_type st;
  state_type next_st;

  logic [ADDR_W-1:0] addr_up;
  logic [ADDR_W-1:0] addr_dn;
  logic [ADDR_W-1:0] addr_step;
  logic [3:0]        sel_in;
  logic [3:0]        sel_out;

  always_comb begin
    addr_up   = (st.addr == ADDR_LAST)  ? ADDR_FIRST : st.addr + 1'b1;
    addr_dn   = (st.addr == ADDR_FIRST) ? ADDR_LAST  : st.addr - 1'b1;
    addr_step = st.down ? addr_dn : addr_up;
    // selected slave's bits, absent bits forced dark [R5]
    sel_in    = slave_inputs[{st.addr, 2'b00} +: 4] & slave_in_valid[{st.addr, 2'b00} +: 4];
    sel_out   = slave_outputs[{st.addr, 2'b00} +: 4] & slave_out_valid[{st.addr, 2'b00} +: 4];
  end

  always_comb begin
    next_st = st;
    if (st.flash_cnt >= CNT_W'(FLASH_CNT - 1)) begin
      next_st.flash_cnt = '0;
      next_st.blink     = !st.blink;
    end else begin
      next_st.flash_cnt = st.flash_cnt + 1'b1;
    end
    unique case (st.view)
      BUS_VIEW: begin
        if (dir_p.long_press) begin
          next_st.view = ADDR_VIEW; // [R8]
        end
      end
      ADDR_VIEW: begin
        if (dir_p.long_press) begin
          next_st.view = BUS_VIEW; // [R14]
        end else if (step_p.long_press) begin
          next_st.view = IO_VIEW; // [R10]
        end else begin
          if (step_p.short_press) next_st.addr = addr_step; // [R9]
          if (dir_p.short_press) next_st.down = !st.down; // [R9]
        end
      end
      IO_VIEW: begin
        if (dir_p.long_press) begin
          next_st.view = BUS_VIEW; // [R14]
        end else if (step_p.long_press) begin
          next_st.view = ADDR_VIEW; // [R12]
        end else begin
          if (step_p.short_press) next_st.addr = addr_step; // [R11]
          if (dir_p.short_press) next_st.down = !st.down; // [R11]
        end
      end
      default: next_st.view = BUS_VIEW;
    endcase
    next_st.leds = '0;
    unique case (st.view)
      BUS_VIEW: begin
        // steady on match, blink on mismatch, address 0 unused [R1] [R2]
        next_st.leds = ((slave_expected & slave_detected)
                       | ((slave_expected ^ slave_detected) & {NUM_LEDS{st.blink}}))
                       & ~NUM_LEDS'(1);
      end
      ADDR_VIEW: begin
        next_st.leds[st.addr] = 1'b1; // [R3]
      end
      IO_VIEW: begin
        next_st.leds[IN_LO +: 4]  = sel_in;  // [R4] [R5]
        next_st.leds[OUT_LO +: 4] = sel_out; // [R4] [R5]
      end
      default: next_st.leds = '0;
    endcase
    next_st.bus_on = (st.view == BUS_VIEW); // [R6]
    next_st.io_on  = (st.view == IO_VIEW);  // [R6]
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st        <= '0;
      st.view   <= BUS_VIEW; // [R7]
      st.addr   <= ADDR_FIRST;
      st.bus_on <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign panel_led       = st.leds;
  assign bus_led         = st.bus_on;
  assign io_led          = st.io_on;
  assign slave_view_mode = !st.bus_on;

  // view transitions
  chk_bus_to_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
    (st.view == BUS_VIEW && dir_p.long_press) |=> st.view == ADDR_VIEW)
    else $error("bus view did not enter address view");
  chk_addr_to_io: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R10]
    (st.view == ADDR_VIEW && step_p.long_press && !dir_p.long_press) |=> st.view == IO_VIEW)
    else $error("address view did not enter i/o view");
  chk_io_to_addr: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
    (st.view == IO_VIEW && step_p.long_press && !dir_p.long_press) |=> st.view == ADDR_VIEW)
    else $error("i/o view did not return to address view");
  chk_back_to_bus: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
    (st.view != BUS_VIEW && dir_p.long_press) |=> st.view == BUS_VIEW)
    else $error("long direction press did not return to bus view");
  chk_mode_leds: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R6]
    ##1 (bus_led == ($past(st.view) == BUS_VIEW)) && (io_led == ($past(st.view) == IO_VIEW)))
    else $error("mode leds do not match view");
  // address stepping
  chk_addr_step: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
    (st.view == ADDR_VIEW && step_p.short_press && !st.down && st.addr != ADDR_LAST
     && !dir_p.long_press && !step_p.long_press) |=> st.addr == $past(st.addr) + 5'h01)
    else $error("address did not step up");
  chk_addr_step_down: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
    (st.view == ADDR_VIEW && step_p.short_press && st.down && st.addr != ADDR_FIRST
     && !dir_p.long_press && !step_p.long_press) |=> st.addr == $past(st.addr) - 5'h01)
    else $error("address did not step down");
  chk_dir_reverse: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9] [R11]
    (st.view != BUS_VIEW && dir_p.short_press && !step_p.long_press)
    |=> st.down != $past(st.down))
    else $error("short direction press did not reverse");
  chk_io_step: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R11]
    (st.view == IO_VIEW && step_p.short_press && !dir_p.long_press && !step_p.long_press)
    |=> st.view == IO_VIEW && st.addr != $past(st.addr))
    else $error("i/o view did not move to another slave");
  chk_addr_range: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R9]
    st.addr != 5'h00) else $error("selected address is zero");
  // led content, one cycle behind the view and address
  chk_addr_led: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R3]
    (st.view == ADDR_VIEW) ##1 (st.view == ADDR_VIEW) |-> panel_led == (32'h1 << $past(st.addr)))
    else $error("address view led wrong");
  chk_io_leds: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R4]
    (st.view == IO_VIEW) |=> panel_led[31:8] == 24'h000000)
    else $error("i/o view lit leds above 7");
  chk_bus_led0: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
    (st.view == BUS_VIEW) |=> !panel_led[0]) else $error("led 0 lit in bus view");
  chk_bus_steady: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
    (st.view == BUS_VIEW) |=> ((panel_led ^ ($past(slave_expected) & $past(slave_detected)))
     & ~($past(slave_expected) ^ $past(slave_detected)) & 32'hFFFF_FFFE) == 32'h0000_0000)
    else $error("bus view steady leds wrong");
  cov_enter_addr: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st.view == BUS_VIEW ##1 st.view == ADDR_VIEW);
  cov_enter_io: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st.view == ADDR_VIEW ##1 st.view == IO_VIEW);
  cov_wrap: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st.addr == ADDR_LAST ##1 st.addr == ADDR_FIRST);
  cov_reverse: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(st.down));
  cov_io_step: cover property (@(posedge ref_clk) disable iff (!rst_n)
    st.view == IO_VIEW && step_p.short_press);
endmodule

/* sim/operator_model.sv */
// operator model: presses the direction and step push buttons of the panel
// assumes ref_clk is the display clock; buttons read high while pressed
`timescale 1ns/1ps
module operator_model (
  // clock
  input  wire logic ref_clk,
  // buttons
  output logic      dir_button,
  output logic      step_button
);
  initial begin
    dir_button  <= 1'b0;
    step_button <= 1'b0;
  end

  // holds one button for a number of clock cycles, then lets it go
  task automatic push(input bit dir, input int hold);
    @(posedge ref_clk);
    if (dir) begin
      dir_button <= 1'b1;
    end else begin
      step_button <= 1'b1;
    end
    // a hold of at least the long-press count makes the long press, since release is debounced as long as press
    repeat (hold) @(posedge ref_clk);
    dir_button  <= 1'b0;
    step_button <= 1'b0;
  endtask
endmodule

/* sim/testbench.sv */
// self-checking bench for the diagnostic display, short counts for speed
// assumes the operator model drives both buttons
`timescale 1ns/1ps
module testbench;
  import diag_pkg::*;
  localparam int unsigned LONG = 40, DEB = 3, FLASH = 4, SHORT = 10, HELD = 60;
  logic                ref_clk, rst_n, dir_button, step_button;
  logic [NUM_LEDS-1:0] slave_expected, slave_detected, panel_led;
  logic [127:0]        slave_inputs, slave_outputs, slave_in_valid, slave_out_valid;
  logic                bus_led, io_led, slave_view_mode;
  int                  fails, checked;
  `define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end

  diag_display #(.LONG_CNT(LONG), .DEB_CNT(DEB), .FLASH_CNT(FLASH)) u_diag_display (
    .ref_clk(ref_clk), .rst_n(rst_n), .dir_button(dir_button), .step_button(step_button),
    .slave_expected(slave_expected), .slave_detected(slave_detected),
    .slave_inputs(slave_inputs), .slave_outputs(slave_outputs),
    .slave_in_valid(slave_in_valid), .slave_out_valid(slave_out_valid),
    .panel_led(panel_led), .bus_led(bus_led), .io_led(io_led),
    .slave_view_mode(slave_view_mode));
  operator_model u_operator_model (.ref_clk(ref_clk), .dir_button(dir_button),
    .step_button(step_button));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] io_exp(input int n);
    logic [3:0] a;
    a = n[3:0];
    return {24'h0, ~a & slave_out_valid[4*n+:4], a & slave_in_valid[4*n+:4]};
  endfunction

  task automatic press(input bit dir, input int hold);
    u_operator_model.push(dir, hold);
    repeat (DEB + 10) @(posedge ref_clk);
    // look at the outputs away from the edge that launches them
    @(negedge ref_clk);
  endtask

  task automatic mode(input logic b, input logic io);
    `CHK("bus_led", b, bus_led)
    `CHK("io_led", io, io_led)
    `CHK("slave_view_mode", !b, slave_view_mode)
  endtask

  task automatic t_bus_image;
    logic [31:0] all_on, any_on;
    @(posedge ref_clk);
    slave_expected <= 32'h0000_0813;
    slave_detected <= 32'h0000_1012;
    repeat (4) @(posedge ref_clk);
    all_on = '1;
    any_on = '0;
    repeat (4 * FLASH + 4) begin
      @(negedge ref_clk);
      all_on &= panel_led;
      any_on |= panel_led;
    end
    `CHK("steady", 32'h0000_0012, all_on)
    `CHK("lit", 32'h0000_1812, any_on)
    press(0, SHORT);
    mode(1, 0);
    $display("test bus_image done");
  endtask

  task automatic t_addr;
    press(1, HELD);
    mode(0, 0);
    `CHK("addr1", 32'h0000_0002, panel_led)
    press(0, SHORT);
    `CHK("addr2", 32'h0000_0004, panel_led)
    press(0, 2);
    `CHK("glitch", 32'h0000_0004, panel_led)
    press(1, SHORT);
    press(0, SHORT);
    `CHK("down1", 32'h0000_0002, panel_led)
    press(0, SHORT);
    `CHK("wrap31", 32'h8000_0000, panel_led)
    $display("test addr done");
  endtask

  task automatic t_io;
    press(0, HELD);
    mode(0, 1);
    `CHK("io31", io_exp(31), panel_led)
    press(0, SHORT);
    `CHK("io30", io_exp(30), panel_led)
    press(1, SHORT);
    press(0, SHORT);
    `CHK("io31b", io_exp(31), panel_led)
    press(0, HELD);
    mode(0, 0);
    `CHK("back31", 32'h8000_0000, panel_led)
    press(1, HELD);
    mode(1, 0);
    `CHK("image", 32'h0000_0012, panel_led & 32'h0000_0012)
    $display("test io done");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    fails = 0;
    checked = 0;
    rst_n <= 1'b0;
    slave_expected <= '0;
    slave_detected <= '0;
    for (int n = 0; n < 32; n++) begin
      slave_inputs[4*n+:4]    <= n[3:0];
      slave_outputs[4*n+:4]   <= ~n[3:0];
      slave_in_valid[4*n+:4]  <= (n == 30) ? 4'h3 : 4'hF;
      slave_out_valid[4*n+:4] <= 4'hF;
    end
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    mode(1, 0);
    t_bus_image();
    t_addr();
    t_io();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    conclude();
  end
endmodule
